// [design/t1pm_defs.vh]
// Offsets, field positions, reset values and widths of the performance-monitor counter bank
`ifndef T1PM_DEFS_VH
`define T1PM_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define T1PM_ADDR_W              8
`define T1PM_OFS_FRAME_LOSS      8'h00
`define T1PM_OFS_ALIGN_CHANGE    8'h04
`define T1PM_OFS_CKSUM_ERR       8'h08
`define T1PM_OFS_PRBS_UPPER      8'h0C
`define T1PM_OFS_PRBS_LOWER      8'h10
`define T1PM_OFS_INT_STATUS      8'h14
`define T1PM_OFS_INT_CLEAR       8'h18
`define T1PM_OFS_INT_ENABLE      8'h1C

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define T1PM_CNT8_W              8
`define T1PM_CNT16_W             16
`define T1PM_CNT_RESET           8'h00
`define T1PM_POS_W               8
`define T1PM_INT_W               4
`define T1PM_INT_RESET           4'h0

// ----------------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------------
`define T1PM_INT_FRAME_LOSS      0
`define T1PM_INT_ALIGN_CHANGE    1
`define T1PM_INT_CKSUM_ERR       2
`define T1PM_INT_PRBS_ERR        3

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define T1PM_RESP_OKAY           2'h0
`define T1PM_RESP_SLVERR         2'h2

`endif

// [design/t1pm_perf_monitor.v]
// Performance-monitor counter bank with AXI4-Lite register access and interrupt
//
// Function
// - 8-bit counter, one per new frame loss
// - Counters clear on read, start at zero
// - 8-bit counter of alignment change events
// - Alignment change: new lock differs from candidate
// - 8-bit counter of link controller checksum errors
// - 16-bit PRBS error counter, upper byte register
// - Lower byte register shows bits 7..0 as latched by the last upper byte read (the code clears it to zero on each lower byte read)
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "t1pm_defs.vh"
module t1pm_perf_monitor (
  input  wire                      mclk_i,
  input  wire                      rst_i,
  // Event sources
  input  wire                      frame_loss_i,
  input  wire                      lock_pulse_i,
  input  wire [`T1PM_POS_W-1:0]    lock_pos_i,
  input  wire [`T1PM_POS_W-1:0]    cand_pos_i,
  input  wire                      cksum_err_i,
  input  wire                      prbs_err_i,
  // AXI4-Lite write address
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [`T1PM_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]                s_axi_awprot,
  // AXI4-Lite write data
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  output reg  [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  input  wire [`T1PM_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]                s_axi_arprot,
  // AXI4-Lite read data
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  // Interrupt
  output reg                       irq_o
);

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  reg                      frame_loss_q;
  wire                     loss_event;
  wire                     align_event;
  wire                     pos_differs;
  wire [2:0]               ev8;

  // Count only the declaration edge of a loss condition
  assign loss_event  = frame_loss_i & ~frame_loss_q;
  assign pos_differs = (lock_pos_i != cand_pos_i);
  assign align_event = lock_pulse_i & pos_differs;
  assign ev8         = {cksum_err_i, align_event, loss_event};

  always @(posedge mclk_i) begin
    if (rst_i) begin
      frame_loss_q <= 1'b0;
    end else begin
      frame_loss_q <= frame_loss_i;
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  wire                     rd_fire;
  wire                     rd_loss;
  wire                     rd_align;
  wire                     rd_cksum;
  wire                     rd_upper;
  wire                     rd_lower;
  wire [2:0]               rd8;

  assign rd_fire  = s_axi_arvalid & s_axi_arready;
  assign rd_loss  = rd_fire & (s_axi_araddr == `T1PM_OFS_FRAME_LOSS);
  assign rd_align = rd_fire & (s_axi_araddr == `T1PM_OFS_ALIGN_CHANGE);
  assign rd_cksum = rd_fire & (s_axi_araddr == `T1PM_OFS_CKSUM_ERR);
  assign rd_upper = rd_fire & (s_axi_araddr == `T1PM_OFS_PRBS_UPPER);
  assign rd_lower = rd_fire & (s_axi_araddr == `T1PM_OFS_PRBS_LOWER);
  assign rd8      = {rd_cksum, rd_align, rd_loss};

  // ----------------------------------------------------------------------
  // Eight-bit clear-on-read counters
  // ----------------------------------------------------------------------
  wire [`T1PM_CNT8_W-1:0]  cnt8 [0:2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt8
      // Loss, alignment change and checksum error counters
      t1pm_rc_counter #(
        .WIDTH   (`T1PM_CNT8_W)
      ) u_cnt (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .inc_i   (ev8[gi]),
        .clr_i   (rd8[gi]),
        .count_o (cnt8[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Sixteen-bit PRBS error counter with lower-byte snapshot
  // ----------------------------------------------------------------------
  wire [`T1PM_CNT16_W-1:0] prbs_cnt;
  reg  [`T1PM_CNT8_W-1:0]  prbs_lower;

  t1pm_rc_counter #(
    .WIDTH   (`T1PM_CNT16_W)
  ) u_prbs_cnt (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .inc_i   (prbs_err_i),
    .clr_i   (rd_upper),
    .count_o (prbs_cnt)
  );

  // Upper read freezes the low byte so the pair stays coherent
  always @(posedge mclk_i) begin
    if (rst_i) begin
      prbs_lower <= `T1PM_CNT_RESET;
    end else if (rd_upper) begin
      prbs_lower <= prbs_cnt[7:0];
    end else if (rd_lower) begin
      prbs_lower <= `T1PM_CNT_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  reg                      aw_got;
  reg                      w_got;
  reg  [`T1PM_ADDR_W-1:0]  wr_addr;
  reg  [31:0]              wr_data;
  reg  [3:0]               wr_strb;
  wire                     wr_fire;
  wire                     wr_clear;
  wire                     wr_enable;
  reg                      wr_ok;

  assign wr_fire   = aw_got & w_got & ~s_axi_bvalid;
  assign wr_clear  = wr_fire & (wr_addr == `T1PM_OFS_INT_CLEAR) & wr_strb[0];
  assign wr_enable = wr_fire & (wr_addr == `T1PM_OFS_INT_ENABLE) & wr_strb[0];

  // Only the clear and enable words take writes
  always @* begin
    case (wr_addr)
      `T1PM_OFS_INT_CLEAR:  wr_ok = 1'b1;
      `T1PM_OFS_INT_ENABLE: wr_ok = 1'b1;
      default:              wr_ok = 1'b0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `T1PM_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      wr_addr       <= {`T1PM_ADDR_W{1'b0}};
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `T1PM_RESP_OKAY : `T1PM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------------
  reg  [`T1PM_INT_W-1:0]   int_status;
  reg  [`T1PM_INT_W-1:0]   int_enable;
  reg  [`T1PM_INT_W-1:0]   int_events;
  reg  [`T1PM_INT_W-1:0]   next_status;
  reg  [`T1PM_INT_W-1:0]   next_enable;
  wire                     next_irq;

  always @* begin
    int_events = `T1PM_INT_RESET;
    int_events[`T1PM_INT_FRAME_LOSS]   = loss_event;
    int_events[`T1PM_INT_ALIGN_CHANGE] = align_event;
    int_events[`T1PM_INT_CKSUM_ERR]    = cksum_err_i;
    int_events[`T1PM_INT_PRBS_ERR]     = prbs_err_i;
  end

  always @* begin
    // New event wins over a clear in the same cycle
    if (wr_clear) begin
      next_status = (int_status & ~wr_data[`T1PM_INT_W-1:0]) | int_events;
    end else begin
      next_status = int_status | int_events;
    end
    next_enable = wr_enable ? wr_data[`T1PM_INT_W-1:0] : int_enable;
  end

  assign next_irq = |(next_status & next_enable);

  always @(posedge mclk_i) begin
    if (rst_i) begin
      int_status <= `T1PM_INT_RESET;
      int_enable <= `T1PM_INT_RESET;
      irq_o      <= 1'b0;
    end else begin
      int_status <= next_status;
      int_enable <= next_enable;
      irq_o      <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  wire [31:0]              word_loss;
  wire [31:0]              word_align;
  wire [31:0]              word_cksum;
  wire [31:0]              word_prbs_upper;
  wire [31:0]              word_prbs_lower;
  wire [31:0]              word_status;
  wire [31:0]              word_enable;

  assign word_loss       = {24'h000000, cnt8[0]};
  assign word_align      = {24'h000000, cnt8[1]};
  assign word_cksum      = {24'h000000, cnt8[2]};
  assign word_prbs_upper = {24'h000000, prbs_cnt[15:8]};
  assign word_prbs_lower = {24'h000000, prbs_lower};
  assign word_status     = {28'h0000000, int_status};
  assign word_enable     = {28'h0000000, int_enable};

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  reg  [31:0]              rd_mux;
  reg                      rd_ok;

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `T1PM_OFS_FRAME_LOSS:   rd_mux = word_loss;
      `T1PM_OFS_ALIGN_CHANGE: rd_mux = word_align;
      `T1PM_OFS_CKSUM_ERR:    rd_mux = word_cksum;
      `T1PM_OFS_PRBS_UPPER:   rd_mux = word_prbs_upper;
      `T1PM_OFS_PRBS_LOWER:   rd_mux = word_prbs_lower;
      `T1PM_OFS_INT_STATUS:   rd_mux = word_status;
      `T1PM_OFS_INT_CLEAR:    rd_mux = 32'h00000000;
      `T1PM_OFS_INT_ENABLE:   rd_mux = word_enable;
      default:                rd_ok = 1'b0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `T1PM_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? `T1PM_RESP_OKAY : `T1PM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [design/t1pm_rc_counter.v]
// Clear-on-read event counter, saturating at its maximum
`timescale 1ns/1ps
module t1pm_rc_counter #(
  parameter WIDTH = 8
) (
  input  wire             mclk_i,
  input  wire             rst_i,
  input  wire             inc_i,
  input  wire             clr_i,
  output reg  [WIDTH-1:0] count_o
);

  wire [WIDTH-1:0] all_ones = {WIDTH{1'b1}};
  reg  [WIDTH-1:0] next_count;

  always @* begin
    if (clr_i) begin
      // Event in the clearing cycle lands in the fresh count
      next_count = inc_i ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    end else if (inc_i && (count_o != all_ones)) begin
      next_count = count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      next_count = count_o;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      count_o <= {WIDTH{1'b0}};
    end else begin
      count_o <= next_count;
    end
  end

endmodule

// [tb/t1pm_perf_monitor_checker.sv]
// Assertion checker on the ports of the counter bank
`timescale 1ns/1ps
module t1pm_perf_monitor_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire w_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  chk_rd_latency: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_rd_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_wr_latency: assert property (w_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
  chk_unmapped_rd: assert property (ar_hs && s_axi_araddr > 8'h1C |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_cnt_width: assert property (ar_hs && s_axi_araddr <= 8'h10 &&
    s_axi_araddr[1:0] == 2'h0 |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0)
    else $error("counter width");
  chk_ro_write: assert property (w_hs && s_axi_awaddr <= 8'h14 |=> ##1
    s_axi_bresp == 2'h2) else $error("counter write accepted");
  chk_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
    else $error("interrupt after reset");
endmodule
bind t1pm_perf_monitor t1pm_perf_monitor_checker u_chk (.*);

// [tb/tb_t1_perf_monitor_counters.sv]
// Self-checking testbench for the counter bank
`timescale 1ns/1ps
module tb_t1_perf_monitor_counters;
  logic mclk_i = 0, rst_i = 1, frame_loss_i = 0, lock_pulse_i = 0;
  logic cksum_err_i = 0, prbs_err_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] lock_pos_i = 0, cand_pos_i = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int error_cnt = 0, n_compared = 0;
  logic [31:0] d;
  logic [1:0] r;
  t1pm_perf_monitor dut (.*);
  initial forever #20 mclk_i = ~mclk_i;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic ev);
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    cksum_err_i <= ev;
    do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    cksum_err_i <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk_i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge mclk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= dd;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end while (pa || pw);
    while (s_axi_bvalid !== 1'b1) @(posedge mclk_i);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  localparam int EV_LOSS = 0, EV_CKSUM = 1, EV_PRBS = 2;
  task automatic pulse(input int sel, input int n);
    @(posedge mclk_i);
    case (sel)
      EV_LOSS:  frame_loss_i <= 1'b1;
      EV_CKSUM: cksum_err_i <= 1'b1;
      default:  prbs_err_i <= 1'b1;
    endcase
    repeat (n) @(posedge mclk_i);
    frame_loss_i <= 1'b0;
    cksum_err_i <= 1'b0;
    prbs_err_i <= 1'b0;
  endtask
  task automatic lk(input logic [7:0] p, input logic [7:0] c);
    @(posedge mclk_i);
    lock_pos_i <= p;
    cand_pos_i <= c;
    lock_pulse_i <= 1'b1;
    @(posedge mclk_i);
    lock_pulse_i <= 1'b0;
  endtask
  task automatic t_reset;
    for (int a = 0; a <= 32'h1C; a += 4) begin
      rd(a[7:0], 1'b0);
      cmp("reset value", 32'h0, d);
      cmp("reset resp", 32'h0, {30'h0, r});
    end
    rd(8'h40, 1'b0);
    cmp("unmapped resp", 32'h2, {30'h0, r});
  endtask
  task automatic t_loss;
    repeat (3) pulse(EV_LOSS, 4);
    rd(8'h00, 1'b0);
    cmp("loss count", 32'h3, d);
    rd(8'h00, 1'b0);
    cmp("loss cleared", 32'h0, d);
  endtask
  task automatic t_align;
    lk(8'h01, 8'h02);
    lk(8'h05, 8'h05);
    lk(8'h07, 8'h03);
    rd(8'h04, 1'b0);
    cmp("align count", 32'h2, d);
  endtask
  task automatic t_cksum;
    pulse(EV_CKSUM, 5);
    rd(8'h08, 1'b0);
    cmp("cksum count", 32'h5, d);
    pulse(EV_CKSUM, 260);
    rd(8'h08, 1'b0);
    cmp("cksum saturated", 32'hFF, d);
  endtask
  task automatic t_prbs;
    pulse(EV_PRBS, 300);
    rd(8'h10, 1'b0);
    cmp("lower alone", 32'h0, d);
    rd(8'h0C, 1'b0);
    cmp("prbs upper", 32'h1, d);
    rd(8'h10, 1'b0);
    cmp("prbs lower", 32'h2C, d);
    rd(8'h0C, 1'b0);
    cmp("prbs cleared", 32'h0, d);
  endtask
  task automatic t_collide;
    rd(8'h08, 1'b1);
    cmp("pre-event read", 32'h0, d);
    rd(8'h08, 1'b0);
    cmp("event kept", 32'h1, d);
  endtask
  task automatic t_irq;
    cmp("irq masked", 32'h0, {31'h0, irq_o});
    rd(8'h14, 1'b0);
    cmp("status", 32'hF, d);
    wr(8'h1C, 32'h4);
    cmp("enable resp", 32'h0, {30'h0, r});
    cmp("irq raised", 32'h1, {31'h0, irq_o});
    wr(8'h18, 32'hF);
    cmp("irq cleared", 32'h0, {31'h0, irq_o});
    pulse(EV_CKSUM, 1);
    @(posedge mclk_i);
    cmp("irq event", 32'h1, {31'h0, irq_o});
    rd(8'h18, 1'b0);
    cmp("clear reads zero", 32'h0, d);
    wr(8'h00, 32'h1);
    cmp("counter write", 32'h2, {30'h0, r});
    wr(8'h40, 32'h0);
    cmp("unmapped write", 32'h2, {30'h0, r});
  endtask
  task automatic test_done;
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset;
    t_loss;
    t_align;
    t_cksum;
    t_prbs;
    t_collide;
    t_irq;
    test_done;
  end
endmodule
